// >>> design/smc_pkg.sv
// constants, states and carriers of the serial mram command block
// assumes one core clock of 4 ns and a host-driven serial clock
package smc_pkg;
  // opcodes fixed by the command set
  localparam logic [7:0] OP_READ    = 8'h03;
  localparam logic [7:0] OP_WRITE   = 8'h02;
  localparam logic [7:0] OP_STATUS  = 8'h05;
  localparam logic [7:0] OP_PD_EXIT = 8'hab;
  // defaults for opcodes the block must know but which are left open
  localparam logic [7:0] OP_LATCH_SET_DEF = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR_DEF = 8'h04;
  localparam logic [7:0] OP_PD_ENTRY_DEF  = 8'hb9;
  localparam logic [7:0] OP_RST_ARM_DEF   = 8'h66;
  localparam logic [7:0] OP_RST_DEF       = 8'h99;
  localparam logic [7:0] OP_XREAD_DEF     = 8'h0b;
  localparam logic [7:0] OP_XWRITE_DEF    = 8'h0a;
  // instruction layout
  localparam int          CMD_BITS     = 8;
  localparam int          ADDR_BITS    = 24;
  localparam int          ADDR_IGNORED = 7;
  localparam logic [3:0]  CONT_NIBBLE  = 4'ha;
  localparam int          STAT_WEL     = 1;
  // latch policy codes
  localparam logic [1:0]  POL_NORMAL   = 2'b00;
  localparam logic [1:0]  POL_IGNORE   = 2'b01;
  localparam logic [1:0]  POL_B2B      = 2'b10;
  // wrap geometry: 000 is the smallest block, 111 reserved
  localparam logic [23:0] WRAP_MIN     = 24'h000010;
  localparam logic [2:0]  WLEN_RSVD    = 3'b111;
  // hardware reset: cs low pulses, clock idle
  localparam logic [2:0]  HWRST_PULSES = 3'd4;
  // timing in its own units, then cycles at the core rate
  localparam longint CLK_PS   = 4000;
  localparam longint ENTRY_NS = 1000;
  localparam longint EXIT_NS  = 25000;
  localparam longint WAKE_NS  = 50;
  localparam longint CSL_NS   = 500;
  localparam longint RESET_NS = 2000000;
  localparam int ENTRY_CYC = int'((ENTRY_NS * 1000) / CLK_PS);
  localparam int EXIT_CYC  = int'((EXIT_NS * 1000) / CLK_PS);
  localparam int WAKE_CYC  = int'((WAKE_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam int CSL_CYC   = int'((CSL_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam int RESET_CYC = int'((RESET_NS * 1000) / CLK_PS);
  // core power/reset states
  typedef enum logic [4:0] {
    CS_ACT = 5'b00001, CS_ENTER = 5'b00010, CS_DOWN = 5'b00100,
    CS_WAKE = 5'b01000, CS_RST = 5'b10000
  } smc_core_st_t;
  // link phases
  typedef enum logic [7:0] {
    LK_CMD = 8'h01, LK_ADDR = 8'h02, LK_MODE = 8'h04, LK_DUMMY = 8'h08,
    LK_RD = 8'h10, LK_WR = 8'h20, LK_STAT = 8'h40, LK_IDLE = 8'h80
  } smc_link_st_t;
  // configuration bits from the surrounding chip
  typedef struct packed {
    logic [1:0] write_latch_policy;
    logic       wrap_enable_bit;
    logic [2:0] wrap_length_field;
  } smc_cfg_t;
  // link domain state
  typedef struct packed {
    smc_link_st_t st;
    logic [4:0]   cnt;
    logic [7:0]   cmd;
    logic [3:0]   nbits;
    logic [23:0]  addr;
    logic [7:0]   sh;
    logic         wrote;
    logic         wr_op;
    logic         xip_op;
    logic         cont;
    logic         ftog;
    logic         lat_s1;
    logic         lat_s2;
    logic         pd_s1;
    logic         pd_s2;
    smc_cfg_t     cfg_s1;
    smc_cfg_t     cfg_s2;
  } smc_link_t;
  // core domain state
  typedef struct packed {
    smc_core_st_t st;
    logic         cs_s1;
    logic         cs_s2;
    logic         cs_q;
    logic         seen;
    logic         lat;
    logic         armed;
    logic [19:0]  tmr;
    logic [7:0]   lvl;
    logic [2:0]   pulses;
  } smc_core_t;
endpackage

// >>> design/smc_top.sv
// serial mram command block: link side on sck, power and latch side on clk
// assumes spi mode 0, single line, host holds cs_n high between frames
`timescale 1ns/1ps
module smc_top import smc_pkg::*; #(
  parameter int         ADDR_W      = ADDR_BITS - ADDR_IGNORED, // array address width
  parameter int         READ_LAT    = 8,                        // dummy cycles, continuous read
  parameter int         EXIT_CYCLES = EXIT_CYC,                 // wake delay in clk cycles
  parameter int         RST_CYCLES  = RESET_CYC,                // reset time in clk cycles
  parameter logic [7:0] OP_LSET     = OP_LATCH_SET_DEF,
  parameter logic [7:0] OP_LCLR     = OP_LATCH_CLR_DEF,
  parameter logic [7:0] OP_PDE      = OP_PD_ENTRY_DEF,
  parameter logic [7:0] OP_ARM      = OP_RST_ARM_DEF,
  parameter logic [7:0] OP_SOFT_RESET_CMD     = OP_RST_DEF,
  parameter logic [7:0] OP_XRD      = OP_XREAD_DEF,
  parameter logic [7:0] OP_XWR      = OP_XWRITE_DEF
) (
  input  wire logic     clk,
  input  wire logic     rst,
  input  wire logic     sck,
  input  wire logic     cs_n,
  input  wire logic     si,
  output logic          so,
  output logic          so_oe,
  input  wire smc_cfg_t cfg,
  output logic          write_enable_latch,
  output logic          continuous_command_mode,
  output logic          power_down,
  output logic          ready
);
  localparam int LAT_B   = READ_LAT;
  localparam int ENTRY_B = ENTRY_CYC;

  smc_link_t  lk_r, lk_nxt;            // link state
  smc_core_t  cr_r, cr_nxt;            // core state
  logic [7:0] mem [0:(1<<ADDR_W)-1];   // the array itself
  logic       fresh_r;                 // no edge yet in this frame
  logic       so_r;                    // output bit, changes on falling sck
  logic       we_c;                    // write strobe for the array
  logic [7:0] wd_c;                    // byte being stored
  logic [7:0] stat_c;                  // status byte as seen by the link
  logic       rise;                    // synced cs rising edge
  logic       fall;                    // synced cs falling edge
  logic       clocked;                 // the frame saw at least one edge
  logic       one_cmd;                 // frame held exactly one command

  // next read address: wraps inside the block or rolls over linearly
  function automatic logic [23:0] nxt_rd(input logic [23:0] a, input smc_cfg_t c);
    logic [23:0] m;
    m = (WRAP_MIN << c.wrap_length_field) - 24'd1;
    if (c.wrap_enable_bit && c.wrap_length_field != WLEN_RSVD) begin
      nxt_rd = (a & ~m) | ((a + 24'd1) & m);
    end else begin
      nxt_rd = a + 24'd1;
    end
  endfunction

  always_comb begin
    stat_c           = '0;
    stat_c[STAT_WEL] = lk_r.lat_s2;
  end

  // link logic: one bit per rising sck, state held after cs rises
  always_comb begin
    lk_nxt = lk_r;
    we_c   = 1'b0;
    wd_c   = {lk_r.sh[6:0], si};
    // synchronisers for core-side levels and static configuration
    lk_nxt.lat_s1 = cr_r.lat;
    lk_nxt.lat_s2 = lk_r.lat_s1;
    lk_nxt.pd_s1  = (cr_r.st != CS_ACT);
    lk_nxt.pd_s2  = lk_r.pd_s1;
    lk_nxt.cfg_s1 = cfg;
    lk_nxt.cfg_s2 = lk_r.cfg_s1;
    // first edge of a frame: continuous mode skips the command
    if (fresh_r) begin
      lk_nxt.st    = lk_r.cont ? LK_ADDR : LK_CMD;
      lk_nxt.cnt   = '0;
      lk_nxt.nbits = '0;
      lk_nxt.wrote = 1'b0;
      lk_nxt.ftog  = ~lk_r.ftog;
    end
    // bit count saturates above a lone command
    if (lk_nxt.nbits != 4'd9) begin
      lk_nxt.nbits = lk_nxt.nbits + 4'd1;
    end
    case (lk_nxt.st)
      LK_CMD: begin
        lk_nxt.cmd = {lk_nxt.cmd[6:0], si};
        lk_nxt.cnt = lk_nxt.cnt + 5'd1;
        if (lk_nxt.cnt == 5'(CMD_BITS)) begin
          lk_nxt.cnt    = '0;
          lk_nxt.st     = LK_IDLE;
          lk_nxt.wr_op  = (lk_nxt.cmd == OP_WRITE) || (lk_nxt.cmd == OP_XWR);
          lk_nxt.xip_op = (lk_nxt.cmd == OP_XRD) || (lk_nxt.cmd == OP_XWR);
          if (lk_r.pd_s2) begin
            lk_nxt.st = LK_IDLE;                     // asleep: only the core looks
          end else if (lk_nxt.cmd == OP_READ || lk_nxt.cmd == OP_WRITE ||
                       lk_nxt.xip_op) begin
            lk_nxt.st = LK_ADDR;
          end else if (lk_nxt.cmd == OP_STATUS) begin
            lk_nxt.st = LK_STAT;
            lk_nxt.sh = stat_c;
          end
        end
      end
      LK_ADDR: begin
        lk_nxt.addr = {lk_nxt.addr[22:0], si};
        lk_nxt.cnt  = lk_nxt.cnt + 5'd1;
        if (lk_nxt.cnt == 5'(ADDR_BITS)) begin
          lk_nxt.cnt = '0;
          if (lk_nxt.xip_op) begin
            lk_nxt.st = LK_MODE;
          end else if (lk_nxt.wr_op) begin
            lk_nxt.st    = LK_WR;
            lk_nxt.wrote = 1'b1;
          end else begin
            lk_nxt.st = LK_RD;
            lk_nxt.sh = mem[lk_nxt.addr[ADDR_W-1:0]]; // upper bits ignored
          end
        end
      end
      LK_MODE: begin
        lk_nxt.sh  = {lk_nxt.sh[6:0], si};
        lk_nxt.cnt = lk_nxt.cnt + 5'd1;
        if (lk_nxt.cnt == 5'd8) begin
          lk_nxt.cnt  = '0;
          lk_nxt.cont = (lk_nxt.sh[7:4] == CONT_NIBBLE);
          if (lk_nxt.wr_op) begin
            lk_nxt.st    = LK_WR;
            lk_nxt.wrote = 1'b1;
          end else begin
            lk_nxt.st = LK_DUMMY;
          end
        end
      end
      LK_DUMMY: begin
        // latency lets the array settle before the first output bit
        lk_nxt.cnt = lk_nxt.cnt + 5'd1;
        if (lk_nxt.cnt == 5'(LAT_B)) begin
          lk_nxt.cnt = '0;
          lk_nxt.st  = LK_RD;
          lk_nxt.sh  = mem[lk_nxt.addr[ADDR_W-1:0]];
        end
      end
      LK_RD: begin
        lk_nxt.sh  = {lk_nxt.sh[6:0], 1'b0};
        lk_nxt.cnt = lk_nxt.cnt + 5'd1;
        if (lk_nxt.cnt == 5'd8) begin
          lk_nxt.cnt  = '0;
          lk_nxt.addr = nxt_rd(lk_nxt.addr, lk_r.cfg_s2);
          lk_nxt.sh   = mem[lk_nxt.addr[ADDR_W-1:0]];
        end
      end
      LK_WR: begin
        lk_nxt.sh  = {lk_nxt.sh[6:0], si};
        lk_nxt.cnt = lk_nxt.cnt + 5'd1;
        if (lk_nxt.cnt == 5'd8) begin
          lk_nxt.cnt = '0;
          // refused bytes are dropped silently, the burst goes on
          we_c = (lk_r.cfg_s2.write_latch_policy == POL_IGNORE) || lk_r.lat_s2;
          lk_nxt.addr = lk_nxt.addr + 24'd1;        // writes never wrap
        end
      end
      LK_STAT: begin
        lk_nxt.sh  = {lk_nxt.sh[6:0], 1'b0};
        lk_nxt.cnt = lk_nxt.cnt + 5'd1;
        if (lk_nxt.cnt == 5'd8) begin
          lk_nxt.cnt = '0;
          lk_nxt.sh  = stat_c;                       // repeats while clocked
        end
      end
      LK_IDLE: begin
        lk_nxt.cnt = '0;
      end
      default: begin
        lk_nxt.st = LK_IDLE;
      end
    endcase
  end

  // link registers; cs never resets them so the core can read the summary
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      lk_r        <= '0;
      lk_r.st     <= LK_IDLE;
      lk_r.cfg_s1 <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  // array write port on the link clock
  always_ff @(posedge sck) begin
    if (we_c) begin
      mem[lk_r.addr[ADDR_W-1:0]] <= wd_c;
    end
  end

  // marks the first edge of each frame; cs high sets it
  always_ff @(posedge sck or posedge rst or posedge cs_n) begin
    if (rst || cs_n) begin
      fresh_r <= 1'b1;
    end else begin
      fresh_r <= 1'b0;
    end
  end

  // output bit launched on the falling edge, sampled by the host on rising
  always_ff @(negedge sck or posedge rst) begin
    if (rst) begin
      so_r <= 1'b0;
    end else begin
      so_r <= lk_r.sh[7];
    end
  end

  assign so    = so_r;
  // no drive while asleep or waking, nor before the frame's first edge
  assign so_oe = ~cs_n & ~fresh_r & ~lk_r.pd_s2 &
                 ((lk_r.st == LK_RD) || (lk_r.st == LK_STAT));

  // frame summary is stable while sck is quiet after cs rises
  assign rise    = cr_r.cs_s2 & ~cr_r.cs_q;
  assign fall    = ~cr_r.cs_s2 & cr_r.cs_q;
  assign clocked = (lk_r.ftog != cr_r.seen);
  assign one_cmd = clocked && (lk_r.nbits == 4'(CMD_BITS));

  // core logic: latch, arm, power and reset sequencing on clk
  always_comb begin
    cr_nxt       = cr_r;
    cr_nxt.cs_s1 = cs_n;
    cr_nxt.cs_s2 = cr_r.cs_s1;
    cr_nxt.cs_q  = cr_r.cs_s2;
    cr_nxt.lvl   = (rise || fall) ? 8'd0 : ((cr_r.lvl == 8'hff) ? cr_r.lvl : cr_r.lvl + 8'd1);
    if (cr_r.tmr != '0) begin
      cr_nxt.tmr = cr_r.tmr - 20'd1;
    end
    if (rise) begin
      cr_nxt.seen = lk_r.ftog;
    end
    case (cr_r.st)
      CS_ACT: begin
        // a high phase too short breaks the reset pulse train
        if (fall && cr_r.lvl < 8'(CSL_CYC)) begin
          cr_nxt.pulses = '0;
        end
        if (rise && !clocked) begin
          if (cr_r.lvl >= 8'(CSL_CYC)) begin
            cr_nxt.pulses = cr_r.pulses + 3'd1;
            if (cr_r.pulses + 3'd1 == HWRST_PULSES) begin
              cr_nxt.st  = CS_RST;
              cr_nxt.tmr = 20'(RST_CYCLES - 1);
            end
          end else begin
            cr_nxt.pulses = '0;
          end
        end else if (rise) begin
          cr_nxt.pulses = '0;
          if (one_cmd && lk_r.cmd == OP_LSET) begin
            cr_nxt.lat = 1'b1;
          end else if (one_cmd && lk_r.cmd == OP_LCLR) begin
            cr_nxt.lat = 1'b0;
          end else if (one_cmd && lk_r.cmd == OP_PDE) begin
            cr_nxt.st  = CS_ENTER;
            cr_nxt.tmr = 20'(ENTRY_CYC - 1);
          end else if (one_cmd && lk_r.cmd == OP_ARM) begin
            cr_nxt.armed = 1'b1;
          end else if (one_cmd && lk_r.cmd == OP_SOFT_RESET_CMD && cr_r.armed) begin
            cr_nxt.st  = CS_RST;
            cr_nxt.tmr = 20'(RST_CYCLES - 1);
          end else if (lk_r.wrote) begin
            // back-to-back and latch-free policies keep the latch
            if (cfg.write_latch_policy != POL_IGNORE && cfg.write_latch_policy != POL_B2B) begin
              cr_nxt.lat = 1'b0;
            end
          end
          if (!(one_cmd && lk_r.cmd == OP_ARM)) begin
            cr_nxt.armed = 1'b0;                     // arm must come right before
          end
        end
      end
      CS_ENTER: begin
        if (cr_r.tmr == '0) begin
          cr_nxt.st = CS_DOWN;
        end
      end
      CS_DOWN: begin
        // latch and config survive sleep untouched
        if (rise && ((one_cmd && lk_r.cmd == OP_PD_EXIT) ||
                     cr_r.lvl >= 8'(WAKE_CYC))) begin
          cr_nxt.st  = CS_WAKE;
          cr_nxt.tmr = 20'(EXIT_CYCLES - 1);
        end
      end
      CS_WAKE: begin
        if (cr_r.tmr == '0) begin
          cr_nxt.st = CS_ACT;
        end
      end
      CS_RST: begin
        cr_nxt.lat    = 1'b0;
        cr_nxt.armed  = 1'b0;
        cr_nxt.pulses = '0;
        if (cr_r.tmr == '0) begin
          cr_nxt.st = CS_ACT;
        end
      end
      default: begin
        cr_nxt.st = CS_ACT;
      end
    endcase
  end

  // core registers; synchroniser stages reset high like an idle cs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cr_r       <= '0;
      cr_r.st    <= CS_ACT;
      cr_r.cs_s1 <= 1'b1;
      cr_r.cs_s2 <= 1'b1;
      cr_r.cs_q  <= 1'b1;
    end else begin
      cr_r <= cr_nxt;
    end
  end

  assign write_enable_latch      = cr_r.lat;
  assign continuous_command_mode = lk_r.cont;
  assign power_down              = (cr_r.st == CS_DOWN);
  assign ready                   = (cr_r.st == CS_ACT);

  latch_set_a: assert property (@(posedge clk) disable iff (rst)
    (cr_r.st == CS_ACT && rise && one_cmd && lk_r.cmd == OP_LSET) |=> cr_r.lat)
    else $error("latch not set by enable command");
  write_clear_a: assert property (@(posedge clk) disable iff (rst)
    (cr_r.st == CS_ACT && rise && clocked && lk_r.wrote && cfg.write_latch_policy == POL_NORMAL)
    |=> !cr_r.lat)
    else $error("latch kept after write in normal policy");
  b2b_keep_a: assert property (@(posedge clk) disable iff (rst)
    (cr_r.st == CS_ACT && rise && clocked && lk_r.wrote && cr_r.lat &&
     cfg.write_latch_policy == POL_B2B) |=> cr_r.lat)
    else $error("latch lost in back-to-back policy");
  entry_time_a: assert property (@(posedge clk) disable iff (rst)
    $rose(cr_r.st == CS_ENTER) |-> ##[1:ENTRY_B] (cr_r.st == CS_DOWN))
    else $error("power down not reached in entry delay");
  soft_reset_cmd_ignore_a: assert property (@(posedge clk) disable iff (rst)
    (cr_r.st == CS_ACT && rise && one_cmd && lk_r.cmd == OP_SOFT_RESET_CMD && !cr_r.armed)
    |=> (cr_r.st == CS_ACT))
    else $error("soft reset taken without arm");
  exit_cmd_a: assert property (@(posedge clk) disable iff (rst)
    (cr_r.st == CS_DOWN && rise && one_cmd && lk_r.cmd == OP_PD_EXIT) |=> (cr_r.st == CS_WAKE))
    else $error("exit command did not wake");
  wake_quiet_a: assert property (@(posedge clk) disable iff (rst)
    (cr_r.st == CS_WAKE) |-> !so_oe)
    else $error("output driven while waking");
  read_decode_a: assert property (@(posedge sck) disable iff (rst)
    (!fresh_r && !lk_r.pd_s2 && lk_r.st == LK_CMD && lk_r.cnt == 5'd7 &&
     {lk_r.cmd[6:0], si} == OP_READ) |=> (lk_r.st == LK_ADDR))
    else $error("read command not followed by address");
  cont_latency_a: assert property (@(posedge sck) disable iff (rst)
    (lk_r.st == LK_MODE && lk_r.cnt == 5'd7 && !lk_r.wr_op && !cs_n) |=> (lk_r.st == LK_DUMMY))
    else $error("continuous read skipped latency");
endmodule

// >>> verif/smc_host.sv
// host-side serial controller model for the mram command block
// assumes spi mode 0, sck made here only inside frames, 160 ns period
`timescale 1ns/1ps
module smc_host (
  output logic     sck,
  output logic     cs_n,
  output logic     si,
  input  wire logic so,
  input  wire logic so_oe
);
  // idle: clock low, chip select high
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end

  // one frame: tx bytes, then nrx bytes sampled, then xbits stray edges
  task automatic xfer(input logic [7:0] tx[$], input int nrx, input int xbits, output logic [7:0] rx[$]);
    logic [7:0] b;
    int         i;
    int         k;
    rx   = {};
    cs_n = 1'b0;
    #80;
    for (i = 0; i < tx.size() + nrx; i++) begin
      b = (i < tx.size()) ? tx[i] : 8'h00;
      for (k = 7; k >= 0; k--) begin
        si = b[k]; // msb first
        #80 sck = 1'b1;
        b[k] = so; // so was launched on the previous falling edge
        #80 sck = 1'b0;
      end
      if (i >= tx.size()) begin
        rx.push_back(b);
      end
    end
    // extra edges spoil a single-command frame on purpose
    repeat (xbits) begin
      #80 sck = 1'b1;
      #80 sck = 1'b0;
    end
    #80 cs_n = 1'b1;
    si = ~si; // released data line must not keep its last value
    #40; // minimum chip-select high gap
  endtask

  // short chip-select pulse, clock idle
  task automatic wake_pulse();
    cs_n = 1'b0;
    #100 cs_n = 1'b1;
    #40;
  endtask

  // four long high/low phases of 520 ns each; the last rise is followed only by
  // the short gap, so the bench still sees the reset window that it starts
  task automatic hw_reset();
    repeat (4) begin
      #520 cs_n = 1'b0;
      #520 cs_n = 1'b1;
    end
    #40;
  endtask
endmodule

// >>> verif/smc_top_tb_top.sv
// self-checking bench of the mram command block with a host model
// assumes small exit and reset counts so the run stays short
`timescale 1ns/1ps
module smc_top_tb_top;
  import smc_pkg::*;
  typedef struct packed {
    logic [7:0] op;
    logic       wel;
  } smc_row_t;
  logic       clk;
  logic       rst;
  smc_cfg_t   cfg;
  wire        sck;
  wire        cs_n;
  wire        si;
  wire        so;
  wire        so_oe;
  wire        wel;
  wire        cont;
  wire        pd;
  wire        rdy;
  int         n_fail;
  int         comparisons;
  logic [7:0] rx[$];

  smc_top #(.EXIT_CYCLES(40), .RST_CYCLES(60)) i_dut (
    .clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .cfg(cfg),
    .write_enable_latch(wel), .continuous_command_mode(cont), .power_down(pd), .ready(rdy)
  );
  smc_host i_host (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

  // 250 MHz core clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic stop_test();
    if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  // bounded wait on ready (which=0) or power_down (which=1)
  task automatic wait_for(input int which, input logic v, input int n);
    logic s;
    for (int i = 0; i < n; i++) begin
      s = (which != 0) ? pd : rdy;
      if (s === v) break;
      @(posedge clk);
    end
    s = (which != 0) ? pd : rdy;
    chk((which != 0) ? "power_down" : "ready", 8'(v), 8'(s));
    if (s !== v) stop_test();
  endtask

  task automatic cmd(input logic [7:0] op);
    logic [7:0] q[$];
    q = {op};
    i_host.xfer(q, 0, 0, rx);
  endtask

  task automatic rd(input logic [23:0] a, input int n);
    i_host.xfer('{OP_READ, a[23:16], a[15:8], a[7:0]}, n, 0, rx);
  endtask

  // write, then the long post-write gap before anything else
  task automatic wr(input logic [23:0] a, input logic [7:0] d[$]);
    logic [7:0] q[$];
    q = '{OP_WRITE, a[23:16], a[15:8], a[7:0]};
    q = {q, d};
    i_host.xfer(q, 0, 0, rx);
    #1000;
  endtask

  initial begin
    smc_row_t   rows[6];
    logic [7:0] d[$];
    rows = '{'{8'h06, 1'b1}, '{8'h04, 1'b0}, '{8'h5a, 1'b0}, '{8'h06, 1'b1}, '{8'h06, 1'b1}, '{8'h04, 1'b0}};
    rst = 1'b1;
    cfg = '0;
    n_fail = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    chk("latch", 8'h00, 8'(wel));
    chk("cont", 8'h00, 8'(cont));
    chk("pd", 8'h00, 8'(pd));
    chk("ready", 8'h01, 8'(rdy));
    repeat (3) @(posedge clk);
    // single-command frames and the latch they leave
    foreach (rows[i]) begin
      cmd(rows[i].op);
      chk("row latch", 8'(rows[i].wel), 8'(wel));
    end
    // latch, status, then latched write and read back
    cmd(8'h06);
    i_host.xfer('{OP_STATUS}, 1, 0, rx);
    chk("status", 8'h02, rx[0]);
    wr(24'h000100, '{8'h11, 8'h22});
    chk("latch after wr", 8'h00, 8'(wel));
    wr(24'h000100, '{8'h33}); // no latch: must be dropped
    rd(24'h000100, 2);
    chk("rd0", 8'h11, rx[0]);
    chk("rd1", 8'h22, rx[1]);
    // alternative policies keep the latch
    for (int p = 1; p < 3; p++) begin
      @(posedge clk) #1 cfg.write_latch_policy = 2'(p);
      cmd(8'h06);
      wr(24'h000300, '{8'h55});
      chk("kept latch", 8'h01, 8'(wel));
      cmd(8'h04);
      chk("disable", 8'h00, 8'(wel));
    end
    // roll over the top, ignored high bits
    @(posedge clk) #1 cfg.write_latch_policy = POL_IGNORE;
    wr(24'hffffff, '{8'ha1, 8'ha2});
    rd(24'h000000, 1);
    chk("rollover", 8'ha2, rx[0]);
    // 16-byte wrap
    for (int i = 0; i < 16; i++) d.push_back(8'h40 + 8'(i));
    wr(24'h000200, d);
    @(posedge clk) #1 cfg = '{POL_IGNORE, 1'b1, 3'b000};
    rd(24'h00020e, 4);
    foreach (rx[i]) chk("wrap", 8'h40 + 8'((14 + i) % 16), rx[i]);
    @(posedge clk) #1 cfg = '0;
    // continuous mode read with mode byte and latency byte, then leave it
    i_host.xfer('{OP_XREAD_DEF, 8'h00, 8'h02, 8'h00, 8'ha3, 8'h00}, 1, 0, rx);
    chk("xip data", 8'h40, rx[0]);
    chk("xip on", 8'h01, 8'(cont));
    i_host.xfer('{8'h00, 8'h02, 8'h01, 8'hff, 8'h00}, 1, 0, rx);
    chk("xip cont", 8'h41, rx[0]);
    chk("xip off", 8'h00, 8'(cont));
    // power-down spoiled by a ninth edge
    i_host.xfer('{OP_PD_ENTRY_DEF}, 0, 1, rx);
    repeat (20) @(posedge clk);
    chk("no entry", 8'h01, 8'(rdy));
    // enter, wake by pulse
    cmd(OP_PD_ENTRY_DEF);
    wait_for(0, 1'b0, 10);
    wait_for(1, 1'b1, 300);
    chk("oe asleep", 8'h00, 8'(so_oe));
    i_host.wake_pulse();
    wait_for(1, 1'b0, 20);
    chk("waking", 8'h00, 8'(rdy));
    wait_for(0, 1'b1, 80);
    // enter, wake by exit command
    cmd(OP_PD_ENTRY_DEF);
    wait_for(1, 1'b1, 300);
    cmd(OP_PD_EXIT);
    wait_for(0, 1'b1, 80);
    rd(24'h000100, 1);
    chk("kept data", 8'h11, rx[0]);
    // soft reset needs the arm frame first
    cmd(OP_RST_DEF);
    repeat (10) @(posedge clk);
    chk("unarmed", 8'h01, 8'(rdy));
    cmd(OP_RST_ARM_DEF);
    cmd(OP_RST_DEF);
    wait_for(0, 1'b0, 10);
    wait_for(0, 1'b1, 100);
    // hardware reset by chip-select phases
    i_host.hw_reset();
    wait_for(0, 1'b0, 10);
    wait_for(0, 1'b1, 100);
    stop_test();
  end
endmodule
